// ===== adbs_defines.svh
/*
  Constants for the converter boundary-scan segment: chain layout and the
  idle values that the update stage takes on any reset.
  Assumes inclusion by the package and the segment module only.
*/
`ifndef ADBS_DEFINES_SVH
`define ADBS_DEFINES_SVH

// ----------------------------------------------------------------
// Chain layout
// ----------------------------------------------------------------
`define ADBS_DAC_W 10
`define ADBS_MUX_W 8
`define ADBS_CTRL_W 30
`define ADBS_CHAIN_W 31
`define ADBS_SYNC_W 8
// Synchroniser rest value: test reset released, every strobe low
`define ADBS_SYNC_IDLE 8'h02

// ----------------------------------------------------------------
// Idle values of the control cells
// ----------------------------------------------------------------
`define ADBS_IDLE_SC_CLK 1'h0
`define ADBS_IDLE_PATH_EN 1'h0
`define ADBS_IDLE_NEG_BG 1'h0
`define ADBS_IDLE_POWER 1'h0
`define ADBS_IDLE_GAIN_POWER 1'h0
`define ADBS_IDLE_DAC 10'h200
`define ADBS_IDLE_BYPASS 1'h1
`define ADBS_IDLE_X10 1'h0
`define ADBS_IDLE_X20 1'h0
`define ADBS_IDLE_GROUND 1'h0
`define ADBS_IDLE_HOLD 1'h1
`define ADBS_IDLE_REF_BG 1'h0
`define ADBS_IDLE_MUX 8'h01
`define ADBS_IDLE_LATCH_PRECHARGE_N_N 1'h1

`endif

// ===== adbs_pkg.sv
/*
  Types for the converter boundary-scan segment.
  Assumes adbs_defines.svh is reachable by bare name.
*/
`default_nettype none
`include "adbs_defines.svh"

package adbs_pkg;

  // Converter control inputs, one general scan cell per bit
  typedef struct packed {
    logic sc_clk;
    logic gain_path_en;
    logic neg_bandgap_sel;
    logic conv_power_on;
    logic gain_power_on;
    logic [`ADBS_DAC_W-1:0] dac_code;
    logic gain_bypass_sel;
    logic gain_x10_en;
    logic gain_x20_en;
    logic neg_ground_sel;
    logic hold;
    logic ref_bandgap_sel;
    logic [`ADBS_MUX_W-1:0] input_mux_sel;
    logic latch_precharge_n;
  } adbs_ctrl_type;

  // Test access signals, all from the scan clock domain
  typedef struct packed {
    logic tck;
    logic tdi;
    logic shift_dr;
    logic capture_dr;
    logic update_dr;
    logic extest;
    logic test_reset_n;
  } adbs_scan_type;

  localparam adbs_ctrl_type ADBS_CTRL_IDLE = '{
    sc_clk: `ADBS_IDLE_SC_CLK,
    gain_path_en: `ADBS_IDLE_PATH_EN,
    neg_bandgap_sel: `ADBS_IDLE_NEG_BG,
    conv_power_on: `ADBS_IDLE_POWER,
    gain_power_on: `ADBS_IDLE_GAIN_POWER,
    dac_code: `ADBS_IDLE_DAC,
    gain_bypass_sel: `ADBS_IDLE_BYPASS,
    gain_x10_en: `ADBS_IDLE_X10,
    gain_x20_en: `ADBS_IDLE_X20,
    neg_ground_sel: `ADBS_IDLE_GROUND,
    hold: `ADBS_IDLE_HOLD,
    ref_bandgap_sel: `ADBS_IDLE_REF_BG,
    input_mux_sel: `ADBS_IDLE_MUX,
    latch_precharge_n: `ADBS_IDLE_LATCH_PRECHARGE_N_N
  };

endpackage : adbs_pkg

`default_nettype wire

// ===== adbs_scan_seg.sv
/*
  Boundary-scan segment between the converter's digital control logic and
  its analog side: 30 general control cells and one cell on the comparator.
  Assumes a test access controller outside that drives the scan clock and
  state strobes; all of them arrive asynchronously and are sampled here.
*/
// Notes on behaviour
// R1 - Every converter control and the comparator result has a general scan cell.
// R2 - The tester may skip the converter in connectivity tests since pins are scanned too.
// R3 - The ten-bit DAC code cell sets the comparison level and idles at 0x200.
// R4 - The hold control samples while low and holds while high, idling at 1.
// R5 - With gain stages in use the tester raises hold only while the gain clock is high.
// R6 - The converter power-on control enables the converter when high and idles at 0.
// R7 - The gain-stage power-on control enables the gain stages and idles at 0.
// R8 - The switched-capacitor gain clock control idles at 0.
// R9 - The gain path enable joins gain output to the comparator and idles at 0.
// R10 - The bypass select routes channels 0 to 3 around the gain stages and idles at 1.
// R11 - The ground select ties the comparator negative input low and idles at 0.
// R12 - The latch precharge control is active low and idles at 1.
// R13 - The tester keeps the DAC code at 0x200 while hold is low.
// R14 - The tester selects at most one source for the comparator negative input.
`timescale 1ns/10ps
`default_nettype none
`include "adbs_defines.svh"

module adbs_scan_seg (
  input wire logic i_clk_sys, // System clock, 250 MHz
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire adbs_pkg::adbs_scan_type i_scan, // Test access strobes
  input wire adbs_pkg::adbs_ctrl_type i_func_ctrl, // Controls from core
  input wire logic i_comp, // Comparator result from analog
  output var adbs_pkg::adbs_ctrl_type o_ctrl, // Controls to analog
  output logic o_comp_core, // Comparator result to core
  output logic o_tdo // Serial data out of segment
);
  import adbs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`ADBS_SYNC_W-1:0] sync1_r;
  logic [`ADBS_SYNC_W-1:0] sync2_r;
  adbs_scan_type scan_s;
  logic comp_s;
  logic tck_d_r;
  logic tck_rise;
  logic tck_fall;
  logic test_rst;

  // Rest at the pins' idle levels, so no test reset or edge is seen
  // falsely right after a system reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sync1_r <= `ADBS_SYNC_IDLE;
      sync2_r <= `ADBS_SYNC_IDLE;
    end else begin
      sync1_r <= {i_scan, i_comp};
      sync2_r <= sync1_r;
    end
  end

  assign scan_s = sync2_r[`ADBS_SYNC_W-1:1];
  assign comp_s = sync2_r[0];

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      tck_d_r <= 1'h0;
    end else begin
      tck_d_r <= scan_s.tck;
    end
  end

  // Strobes share one sync delay with the scan clock, so their relative
  // timing is kept; each scan clock phase must last several system clocks.
  assign tck_rise = scan_s.tck & ~tck_d_r;
  assign tck_fall = ~scan_s.tck & tck_d_r;
  assign test_rst = ~scan_s.test_reset_n;

  // ----------------------------------------------------------------
  // Shift stage
  // ----------------------------------------------------------------
  logic [`ADBS_CHAIN_W-1:0] chain_r;

  // R1 capture and shift
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      chain_r <= '0;
    end else if (tck_rise && scan_s.capture_dr) begin
      chain_r <= {i_func_ctrl, comp_s};
    end else if (tck_rise && scan_s.shift_dr) begin
      chain_r <= {scan_s.tdi, chain_r[`ADBS_CHAIN_W-1:1]};
    end
  end

  // Data out changes on the falling scan clock edge, as the standard asks
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_tdo <= 1'h0;
    end else if (tck_fall) begin
      o_tdo <= chain_r[0];
    end
  end

  // ----------------------------------------------------------------
  // Update stage
  // ----------------------------------------------------------------
  adbs_ctrl_type upd_r;
  logic comp_upd_r;

  // R3 R4 R6 R7 idle values on reset
  // R8 R9 R10 R11 R12 idle values too
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || test_rst) begin
      upd_r <= ADBS_CTRL_IDLE;
      comp_upd_r <= 1'h0;
    end else if (tck_fall && scan_s.update_dr) begin
      upd_r <= chain_r[`ADBS_CHAIN_W-1:1];
      comp_upd_r <= chain_r[0];
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  // R1 scan drives analog in test mode
  // The analog side sees a registered copy, so a mode switch never glitches
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_ctrl <= ADBS_CTRL_IDLE;
    end else if (scan_s.extest) begin
      o_ctrl <= upd_r;
    end else begin
      o_ctrl <= i_func_ctrl;
    end
  end

  // R1 comparator observe path
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_comp_core <= 1'h0;
    end else if (scan_s.extest) begin
      o_comp_core <= comp_upd_r;
    end else begin
      o_comp_core <= comp_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  comp_capture_a: assert property ( // R1
    tck_rise && scan_s.capture_dr |=> chain_r[0] == $past(comp_s))
    else $error("comparator not captured");

  chain_shift_a: assert property ( // R1
    tck_rise && scan_s.shift_dr && !scan_s.capture_dr |=>
    chain_r == {$past(scan_s.tdi), $past(chain_r[`ADBS_CHAIN_W-1:1])})
    else $error("chain did not shift");

  dac_idle_a: assert property ( // R3
    test_rst ##1 scan_s.extest [*2] |-> o_ctrl.dac_code == `ADBS_IDLE_DAC)
    else $error("dac code not idle after test reset");

  hold_follow_a: assert property ( // R4
    scan_s.extest ##1 scan_s.extest |-> o_ctrl.hold == $past(upd_r.hold))
    else $error("hold does not follow scan cell");

  power_idle_a: assert property ( // R6
    test_rst |=> !upd_r.conv_power_on && !upd_r.gain_power_on)
    else $error("power controls not idle");

  gain_power_idle_a: assert property ( // R7
    $rose(test_rst) |=> upd_r.gain_power_on == `ADBS_IDLE_GAIN_POWER)
    else $error("gain power not idle");

  sc_clk_idle_a: assert property ( // R8
    test_rst |=> upd_r.sc_clk == `ADBS_IDLE_SC_CLK)
    else $error("gain clock not idle");

  path_idle_a: assert property ( // R9
    test_rst |=> upd_r.gain_path_en == `ADBS_IDLE_PATH_EN)
    else $error("gain path not idle");

  bypass_idle_a: assert property ( // R10
    test_rst |=> upd_r.gain_bypass_sel == `ADBS_IDLE_BYPASS)
    else $error("bypass select not idle");

  ground_idle_a: assert property ( // R11
    test_rst |=> upd_r.neg_ground_sel == `ADBS_IDLE_GROUND)
    else $error("ground select not idle");

  latch_precharge_n_func_a: assert property ( // R12
    !scan_s.extest ##1 !scan_s.extest |->
    o_ctrl.latch_precharge_n == $past(i_func_ctrl.latch_precharge_n))
    else $error("precharge not passed from core");

  tdo_launch_a: assert property ( // R1
    tck_fall |=> o_tdo == $past(chain_r[0]))
    else $error("serial out not launched");

  update_load_a: assert property ( // R1
    tck_fall && scan_s.update_dr && !test_rst |=>
    {upd_r, comp_upd_r} == $past(chain_r))
    else $error("update stage not loaded");

  hold_idle_a: assert property ( // R4
    test_rst |=> upd_r.hold == `ADBS_IDLE_HOLD)
    else $error("hold not idle");

  latch_precharge_n_idle_a: assert property ( // R12
    test_rst |=> upd_r.latch_precharge_n == `ADBS_IDLE_LATCH_PRECHARGE_N_N)
    else $error("precharge not idle");

  comp_observe_a: assert property ( // R1
    scan_s.extest |=> o_comp_core == $past(comp_upd_r))
    else $error("comparator cell not observed");

endmodule : adbs_scan_seg

`default_nettype wire

// ===== adbs_tap_model.sv
/*
  Test access controller model for the converter scan segment.
  Assumes the bench calls its tasks; tck rests low between frames.
*/
`timescale 1ns/10ps
`default_nettype none

module adbs_tap_model (
  input wire logic i_clk_sys, // System clock
  input wire logic i_tdo, // Serial out of segment
  output var adbs_pkg::adbs_scan_type o_scan // Strobes to segment
);
  import adbs_pkg::*;

  initial o_scan = 7'h01;

  // ----------------------------------------------------------------
  // One 64 ns tck period, edges well apart from strobe changes
  // ----------------------------------------------------------------
  task automatic pulse();
    @(negedge i_clk_sys) o_scan.tck = 1'h1;
    repeat (8) @(negedge i_clk_sys);
    o_scan.tck = 1'h0;
    repeat (7) @(negedge i_clk_sys);
  endtask : pulse

  // Capture, 31 shifts, update; dout[0] is the comparator capture
  task automatic scan(input logic [30:0] din, output logic [30:0] dout);
    o_scan.capture_dr = 1'h1;
    pulse();
    o_scan.capture_dr = 1'h0;
    o_scan.shift_dr = 1'h1;
    for (int i = 0; i < 31; i++) begin
      o_scan.tdi = din[i];
      dout[i] = i_tdo;
      pulse();
    end
    o_scan.shift_dr = 1'h0;
    // Released data line must not look like a held stale bit
    o_scan.tdi = ~din[30];
    o_scan.update_dr = 1'h1;
    pulse();
    o_scan.update_dr = 1'h0;
    repeat (8) @(negedge i_clk_sys);
  endtask : scan

  task automatic set_mode(input logic ext);
    o_scan.extest = ext;
  endtask : set_mode

  task automatic test_reset();
    o_scan.test_reset_n = 1'h0;
    repeat (8) @(negedge i_clk_sys);
    o_scan.test_reset_n = 1'h1;
    repeat (4) @(negedge i_clk_sys);
  endtask : test_reset
endmodule : adbs_tap_model

`default_nettype wire

// ===== adbs_scan_seg_bench.sv
/*
  Self-checking bench for the converter scan segment.
  Assumes adbs_pkg and adbs_tap_model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module adbs_scan_seg_bench;
  import adbs_pkg::*;

  logic i_clk_sys, i_reset_n, i_comp, o_comp_core, o_tdo;
  adbs_scan_type scan;
  adbs_ctrl_type func, o_ctrl, c;
  logic [30:0] dout;
  logic [31:0] item;
  logic [31:0] exp_q[$];
  int seed = 32'h8975;
  int bad_count = 0;
  int compares = 0;
  event chk_ev;

  adbs_scan_seg adbs_scan_seg_i (.i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n), .i_scan(scan), .i_func_ctrl(func),
    .i_comp(i_comp), .o_ctrl(o_ctrl), .o_comp_core(o_comp_core),
    .o_tdo(o_tdo));
  adbs_tap_model adbs_tap_model_i (.i_clk_sys(i_clk_sys), .i_tdo(o_tdo),
    .o_scan(scan));

  initial begin
    i_clk_sys = 1'h0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [30:0] seen, input logic [30:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic note(input logic k, input logic [30:0] v);
    exp_q.push_back({k, v});
    ->chk_ev;
  endtask : note

  // Keeps random control words safe for the analog side
  function automatic adbs_ctrl_type legal(input adbs_ctrl_type r);
    legal = r;
    if (r.neg_ground_sel) legal.neg_bandgap_sel = 1'h0;
    if (!r.hold) legal.dac_code = 10'h200;
    if (r.gain_power_on && r.hold) legal.sc_clk = 1'h1;
  endfunction : legal

  // Notes made in one time step share one wake-up, so drain them all
  initial forever begin
    @(chk_ev);
    while (exp_q.size() > 0) begin
      item = exp_q.pop_front();
      if (item[31]) check(dout, item[30:0]);
      else check({o_ctrl, o_comp_core}, item[30:0]);
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    summarize();
  end

  initial begin
    i_reset_n = 1'h0;
    func = ADBS_CTRL_IDLE;
    i_comp = 1'h0;
    repeat (5) @(negedge i_clk_sys);
    note(1'h0, {ADBS_CTRL_IDLE, 1'h0});
    @(negedge i_clk_sys) i_reset_n = 1'h1;
    repeat (3) @(negedge i_clk_sys);
    for (int k = 0; k < 4; k++) begin
      func = legal(30'($random(seed)));
      i_comp = 1'($random(seed));
      repeat (4) @(negedge i_clk_sys);
      note(1'h0, {func, i_comp});
    end
    adbs_tap_model_i.set_mode(1'h1);
    repeat (4) @(negedge i_clk_sys);
    note(1'h0, {ADBS_CTRL_IDLE, 1'h0});
    for (int k = 0; k < 4; k++) begin
      func = legal(30'($random(seed)));
      i_comp = 1'($random(seed));
      c = legal(30'($random(seed)));
      repeat (4) @(negedge i_clk_sys);
      adbs_tap_model_i.scan({c, k[0]}, dout);
      note(1'h1, {func, i_comp});
      note(1'h0, {c, k[0]});
    end
    adbs_tap_model_i.test_reset();
    note(1'h0, {ADBS_CTRL_IDLE, 1'h0});
    @(negedge i_clk_sys);
    summarize();
  end
endmodule : adbs_scan_seg_bench

`default_nettype wire
